// *** core/rbl_byte.sv ***
`timescale 1ns/10ps
module rbl_byte (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // request and result
    input wire rbl_pkg::rbl_req_s i_req,
    output rbl_pkg::rbl_rsp_s o_rsp,
    // open-drain pins, enable high pulls low
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN} rbl_bst_e;
    typedef struct packed {
        rbl_bst_e st;
        rbl_pkg::rbl_cmd_e cmd;
        logic [7:0] div;
        logic [1:0] ph;
        logic [3:0] bit_n;
        logic [8:0] sh;
        logic scl_oe;
        logic sda_oe;
        logic [1:0] sda_s;
        logic [1:0] scl_s;
        rbl_pkg::rbl_rsp_s rsp;
    } rbl_bstate_s;
    rbl_bstate_s s;
    rbl_bstate_s next_s;
    logic tick;

    // master only: pins are driven low or released, never followed as slave
    always_comb begin
        next_s = s;
        next_s.sda_s = {s.sda_s[0], i_sda};
        next_s.scl_s = {s.scl_s[0], i_scl};
        next_s.rsp.done = 1'b0;
        tick = (s.div == 8'h00);
        if (s.st == ST_RUN) begin
            next_s.div = tick ? rbl_pkg::QTR : s.div - 8'h01;
        end
        case (s.st)
            ST_IDLE: begin
                if (i_req.cmd != rbl_pkg::CMD_IDLE) begin
                    next_s.st = ST_RUN;
                    next_s.cmd = i_req.cmd;
                    next_s.ph = 2'd0;
                    next_s.bit_n = 4'd0;
                    next_s.div = rbl_pkg::QTR;
                    next_s.sh = (i_req.cmd == rbl_pkg::CMD_READ) ?
                        {8'hFF, i_req.nack} : {i_req.data, 1'b1};
                end
            end
            ST_RUN: begin
                if (tick) begin
                    next_s.ph = s.ph + 2'd1;
                    case (s.cmd)
                        rbl_pkg::CMD_START: begin
                            case (s.ph)
                                2'd0: begin next_s.sda_oe = 1'b0; next_s.scl_oe = 1'b0; end
                                2'd1: next_s.sda_oe = 1'b1;
                                2'd2: next_s.scl_oe = 1'b1;
                                default: begin next_s.st = ST_IDLE; next_s.rsp.done = 1'b1; end
                            endcase
                        end
                        rbl_pkg::CMD_STOP: begin
                            case (s.ph)
                                2'd0: next_s.sda_oe = 1'b1;
                                2'd1: next_s.scl_oe = 1'b0;
                                2'd2: next_s.sda_oe = 1'b0;
                                default: begin next_s.st = ST_IDLE; next_s.rsp.done = 1'b1; end
                            endcase
                        end
                        default: begin
                            case (s.ph)
                                2'd0: begin
                                    if (s.bit_n == 4'd9) begin
                                        // let data go only once scl is low: no false stop
                                        next_s.sda_oe = 1'b0;
                                        next_s.st = ST_IDLE;
                                        next_s.rsp.done = 1'b1;
                                        next_s.rsp.data = s.sh[8:1];
                                        next_s.rsp.ack_in = ~s.sh[0];
                                    end else begin
                                        next_s.sda_oe = ~s.sh[8];
                                    end
                                end
                                2'd1: next_s.scl_oe = 1'b0;
                                2'd2: begin
                                    // hold while slave stretches clock
                                    if (!s.scl_s[1]) begin
                                        next_s.ph = s.ph;
                                    end else begin
                                        next_s.sh = {s.sh[7:0], s.sda_s[1]};
                                    end
                                end
                                default: begin
                                    next_s.scl_oe = 1'b1;
                                    next_s.bit_n = s.bit_n + 4'd1;
                                end
                            endcase
                        end
                    endcase
                end
            end
            default: next_s.st = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_rsp = s.rsp;
    assign o_scl_oe = s.scl_oe;
    assign o_sda_oe = s.sda_oe;
endmodule

// *** core/rbl_loader.sv ***
`timescale 1ns/10ps
module rbl_loader (
    // clock and reset (power-on reset)
    input wire logic i_mclk,
    input wire logic i_rst,
    // host vendor command port
    input wire logic i_host_we,
    input wire logic i_host_re,
    input wire logic [15:0] i_host_addr,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    output logic o_host_ack,
    output logic o_host_err,
    // processor reset control from firmware request
    input wire logic i_cpu_hold_req,
    output logic o_cpu_reset,
    // runtime controller, control and data registers
    input wire logic i_ctl_wr,
    input wire rbl_pkg::rbl_cmd_e i_ctl_cmd,
    input wire logic i_ctl_nack,
    input wire logic i_dat_wr,
    input wire logic [7:0] i_dat_wdata,
    output logic [7:0] o_dat_rdata,
    output logic o_ctl_busy,
    output logic o_ctl_ack,
    // boot status
    output logic o_boot_busy,
    output logic [47:0] o_vendor_product_device_ids,
    output logic [7:0] o_config,
    // ram port to internal memories
    output rbl_pkg::rbl_ram_s o_ram,
    input wire logic [7:0] i_ram_rdata,
    // two-wire pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    typedef enum logic [3:0] {
        ST_B_START, ST_B_ADW, ST_B_AH, ST_B_AL, ST_B_RS, ST_B_ADR,
        ST_B_RD, ST_B_STOP, ST_RUN_IDLE, ST_RUN_BUSY
    } rbl_st_e;
    typedef struct packed {
        rbl_st_e st;
        logic boot;
        logic [3:0] hdr;
        logic [15:0] len;
        logic [15:0] addr;
        logic [1:0] phase;
        logic [47:0] ids;
        logic [7:0] cfg;
        logic [7:0] dat;
        logic ctl_ack;
        logic host_ack;
        logic host_err;
        logic [7:0] host_rd;
        rbl_pkg::rbl_req_s req;
        rbl_pkg::rbl_ram_s ram;
    } rbl_state_s;
    rbl_state_s s;
    rbl_state_s next_s;
    rbl_pkg::rbl_rsp_s rsp;

    // address within host-editable windows
    function automatic logic in_window(input logic [15:0] a);
        in_window = (a <= rbl_pkg::CODE_HI) ||
            (a >= rbl_pkg::SCR_LO && a <= rbl_pkg::SCR_HI);
    endfunction

    // single byte engine shared by both controllers
    rbl_byte u_byte (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_req(s.req),
        .o_rsp(rsp),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_scl_oe(o_scl_oe),
        .o_sda_oe(o_sda_oe)
    );

    // boot sequence, then runtime command handling
    always_comb begin
        next_s = s;
        next_s.req.cmd = rbl_pkg::CMD_IDLE;
        next_s.ram.we = 1'b0;
        next_s.ram.re = 1'b0;
        next_s.ctl_ack = 1'b0;
        next_s.host_ack = 1'b0;
        next_s.host_err = 1'b0;
        case (s.st)
            ST_B_START, ST_B_ADW, ST_B_AH, ST_B_AL, ST_B_RS, ST_B_ADR, ST_B_STOP: begin
                if (s.phase == 2'd0) begin
                    next_s.phase = 2'd1;
                    case (s.st)
                        ST_B_START, ST_B_RS: next_s.req.cmd = rbl_pkg::CMD_START;
                        ST_B_STOP: next_s.req.cmd = rbl_pkg::CMD_STOP;
                        default: next_s.req.cmd = rbl_pkg::CMD_WRITE;
                    endcase
                    next_s.req.data = (s.st == ST_B_ADW) ? {rbl_pkg::EE_ADDR, 1'b0} :
                        (s.st == ST_B_ADR) ? {rbl_pkg::EE_ADDR, 1'b1} : 8'h00;
                end else if (rsp.done) begin
                    next_s.phase = 2'd0;
                    case (s.st)
                        ST_B_START: next_s.st = ST_B_ADW;
                        ST_B_ADW: next_s.st = rsp.ack_in ? ST_B_AH : ST_B_STOP;
                        ST_B_AH: next_s.st = ST_B_AL;
                        ST_B_AL: next_s.st = ST_B_RS;
                        ST_B_RS: next_s.st = ST_B_ADR;
                        ST_B_ADR: next_s.st = rsp.ack_in ? ST_B_RD : ST_B_STOP;
                        default: begin
                            next_s.st = ST_RUN_IDLE;
                            next_s.boot = 1'b0;
                        end
                    endcase
                end
            end
            ST_B_RD: begin
                // header bytes: ids and config, then length, address, data
                if (s.phase == 2'd0) begin
                    next_s.phase = 2'd1;
                    next_s.req.cmd = rbl_pkg::CMD_READ;
                    next_s.req.nack = (s.hdr == rbl_pkg::HDR_LEN + 4'd3 && s.len == 16'h0001);
                end else if (rsp.done) begin
                    next_s.phase = 2'd0;
                    if (s.hdr < rbl_pkg::HDR_LEN) begin
                        next_s.hdr = s.hdr + 4'd1;
                        if (s.hdr == rbl_pkg::HDR_LEN - 4'd1) begin
                            next_s.cfg = rsp.data;
                        end else if (s.hdr != 4'd0) begin
                            next_s.ids = {s.ids[39:0], rsp.data};
                        end
                    end else if (s.hdr == rbl_pkg::HDR_LEN) begin
                        next_s.hdr = s.hdr + 4'd1;
                        next_s.len[15:8] = rsp.data;
                    end else if (s.hdr == rbl_pkg::HDR_LEN + 4'd1) begin
                        next_s.hdr = s.hdr + 4'd1;
                        next_s.len[7:0] = rsp.data;
                    end else if (s.hdr == rbl_pkg::HDR_LEN + 4'd2) begin
                        next_s.hdr = s.hdr + 4'd1;
                        next_s.addr = {rsp.data, 8'h00};
                    end else begin
                        next_s.len = s.len - 16'h0001;
                        next_s.ram.we = in_window(s.addr);
                        next_s.ram.addr = s.addr;
                        next_s.ram.wdata = rsp.data;
                        next_s.addr = s.addr + 16'h0001;
                        if (s.len == 16'h0001) begin
                            next_s.st = ST_B_STOP;
                        end
                    end
                    // empty image: skip straight to stop
                    if (s.hdr == rbl_pkg::HDR_LEN + 4'd1 &&
                        {s.len[15:8], rsp.data} == 16'h0000) begin
                        next_s.st = ST_B_STOP;
                    end
                end
            end
            ST_RUN_IDLE: begin
                // runtime controller via control and data registers
                if (i_dat_wr) begin
                    next_s.dat = i_dat_wdata;
                end
                if (i_ctl_wr && i_ctl_cmd != rbl_pkg::CMD_IDLE) begin
                    next_s.req.cmd = i_ctl_cmd;
                    next_s.req.data = i_dat_wr ? i_dat_wdata : s.dat;
                    next_s.req.nack = i_ctl_nack;
                    next_s.st = ST_RUN_BUSY;
                end
            end
            ST_RUN_BUSY: begin
                if (rsp.done) begin
                    next_s.dat = rsp.data;
                    next_s.ctl_ack = rsp.ack_in;
                    next_s.st = ST_RUN_IDLE;
                end
            end
            default: next_s.st = ST_RUN_IDLE;
        endcase
        // host access only with processor held and no boot running
        if (i_host_we || i_host_re) begin
            if (o_cpu_reset && !s.boot && in_window(i_host_addr)) begin
                next_s.ram.we = i_host_we;
                next_s.ram.re = i_host_re;
                next_s.ram.addr = i_host_addr;
                next_s.ram.wdata = i_host_wdata;
                next_s.host_ack = 1'b1;
            end else begin
                next_s.host_err = 1'b1;
            end
        end
        if (s.ram.re) begin
            next_s.host_rd = i_ram_rdata;
        end
    end

    // state register; boot armed only by power-on reset
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s <= '0;
            s.boot <= 1'b1;
            s.st <= ST_B_START;
        end else begin
            s <= next_s;
        end
    end

    assign o_cpu_reset = s.boot || i_cpu_hold_req;
    assign o_boot_busy = s.boot;
    assign o_ram = s.ram;
    assign o_host_rdata = s.host_rd;
    assign o_host_ack = s.host_ack;
    assign o_host_err = s.host_err;
    assign o_dat_rdata = s.dat;
    assign o_ctl_busy = (s.st != ST_RUN_IDLE);
    assign o_ctl_ack = s.ctl_ack;
    assign o_vendor_product_device_ids = s.ids;
    assign o_config = s.cfg;
endmodule

// *** include/rbl_pkg.sv ***
package rbl_pkg;
    // ram windows
    localparam logic [15:0] CODE_LO = 16'h0000;
    localparam logic [15:0] CODE_HI = 16'h3FFF;
    localparam logic [15:0] SCR_LO = 16'hE000;
    localparam logic [15:0] SCR_HI = 16'hE1FF;
    // eeprom device address: 1010 + straps 001 (large parts)
    localparam logic [6:0] EE_ADDR = 7'h51;
    // header: marker + 6 id bytes + config byte
    localparam logic [3:0] HDR_LEN = 4'h8;
    // bit period: 100 kHz on 40 MHz clock, quarter phases
    localparam int CLK_HZ = 40000000;
    localparam int BUS_HZ = 100000;
    localparam logic [7:0] QTR = 8'(CLK_HZ / BUS_HZ / 4);
    // byte engine commands
    typedef enum logic [2:0] {
        CMD_IDLE, CMD_START, CMD_WRITE, CMD_READ, CMD_STOP
    } rbl_cmd_e;
    // byte engine request
    typedef struct packed {
        rbl_cmd_e cmd;
        logic [7:0] data;
        logic nack;
    } rbl_req_s;
    // byte engine result
    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic ack_in;
    } rbl_rsp_s;
    // ram write/read port
    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } rbl_ram_s;
endpackage

// *** tb/rbl_ee_model.sv ***
`timescale 1ns/10ps
module rbl_ee_model (
    // wire levels
    input wire logic i_scl,
    input wire logic i_sda,
    // pull-down on sda
    output logic o_sda_oe
);
    localparam logic [6:0] DEV = {4'b1010, 3'b001}; // straps 001
    logic [7:0] mem [16];
    logic [7:0] sh;
    logic [15:0] ptr;
    logic rd;
    int st;
    int bc;
    // quiet start-up state
    initial begin
        o_sda_oe = 0;
        st = 0;
        bc = 0;
        ptr = 0;
        rd = 0;
        sh = 0;
    end
    // start or repeated start opens a frame
    always @(negedge i_sda) if (i_scl) begin
        st = 1;
        bc = 0;
        rd = 0;
    end
    // stop closes the frame, pointer kept
    always @(posedge i_sda) if (i_scl) st = 0;
    // shift in on rising scl, then the ack slot
    always @(posedge i_scl) if (st != 0) begin
        if (bc < 8) begin
            sh = {sh[6:0], i_sda};
            bc++;
        end else begin
            bc = 0;
            if (rd) begin
                ptr++;
                if (i_sda) st = 0; // master nack ends read
            end else if (st == 1) st = (sh[7:1] == DEV) ? (sh[0] ? 4 : 2) : 0;
            else if (st == 2) begin
                ptr[15:8] = sh;
                st = 3;
            end else if (st == 3) begin
                ptr[7:0] = sh;
                st = 5;
            end
            rd = (st == 4);
        end
    end
    // change sda only on falling scl, then hold it through the high phase
    always @(negedge i_scl) begin
        if (st == 0) o_sda_oe = 0;
        else if (bc == 8) o_sda_oe = !rd && (st != 1 || sh[7:1] == DEV);
        else o_sda_oe = rd && !mem[ptr[3:0]][3'(7 - bc)];
    end
endmodule

// *** tb/rbl_loader_chk.sv ***
`timescale 1ns/10ps
module rbl_loader_chk (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // watched ports
    input wire logic i_host_we,
    input wire logic i_host_re,
    input wire logic [15:0] i_host_addr,
    input wire logic i_cpu_hold_req,
    input wire logic o_host_ack,
    input wire logic o_host_err,
    input wire logic o_cpu_reset,
    input wire logic o_ctl_busy,
    input wire logic o_ctl_ack,
    input wire logic o_boot_busy,
    input wire rbl_pkg::rbl_ram_s o_ram
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // address falls in a host window
    function automatic logic in_win(logic [15:0] a);
        return a <= rbl_pkg::CODE_HI || (a >= rbl_pkg::SCR_LO && a <= rbl_pkg::SCR_HI);
    endfunction
    boot_holds_cpu_a: assert property (o_boot_busy |-> o_cpu_reset)
        else $error("cpu running during boot");
    cpu_release_a: assert property ((!o_boot_busy && !i_cpu_hold_req) [*2] |-> !o_cpu_reset)
        else $error("cpu not released");
    host_window_a: assert property (o_host_ack |-> in_win($past(i_host_addr)))
        else $error("host ack outside window");
    host_refuse_a: assert property ((i_host_we || i_host_re) && (!o_cpu_reset
        || !in_win(i_host_addr)) |=> o_host_err && !o_host_ack)
        else $error("host access not refused");
    boot_refuse_a: assert property ((i_host_we || i_host_re) && o_boot_busy
        |=> o_host_err)
        else $error("host access during boot");
    host_write_a: assert property (i_host_we && o_cpu_reset && !o_boot_busy && in_win(i_host_addr)
        |=> o_host_ack && o_ram.we && o_ram.addr == $past(i_host_addr))
        else $error("host write lost");
    boot_once_a: assert property (!o_boot_busy |=> !o_boot_busy)
        else $error("boot restarted");
    ram_window_a: assert property (o_ram.we |-> in_win(o_ram.addr))
        else $error("ram write outside window");
    boot_blocks_a: assert property (o_boot_busy |-> o_ctl_busy)
        else $error("runtime free during boot");
    ack_pulse_a: assert property (o_ctl_ack |=> !o_ctl_ack)
        else $error("ack longer than a cycle");
    // main scenarios
    cover property ($fell(o_boot_busy));
    cover property (o_host_ack);
    cover property (o_host_err);
    cover property (o_ctl_ack);
endmodule
bind rbl_loader rbl_loader_chk rbl_loader_chk_i (.i_mclk, .i_rst, .i_host_we, .i_host_re,
    .i_host_addr, .i_cpu_hold_req, .o_host_ack, .o_host_err, .o_cpu_reset, .o_ctl_busy,
    .o_ctl_ack, .o_boot_busy, .o_ram);

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] IMG_MARK = 8'hA5; // image marker, plain default
    logic i_mclk = 0;
    logic i_rst = 1;
    logic i_host_we = 0, i_host_re = 0, i_cpu_hold_req = 0;
    logic i_ctl_wr = 0, i_ctl_nack = 0, i_dat_wr = 0;
    logic [15:0] i_host_addr = 0;
    logic [7:0] i_host_wdata = 0, i_dat_wdata = 0, i_ram_rdata, o_host_rdata, o_dat_rdata;
    rbl_pkg::rbl_cmd_e i_ctl_cmd = rbl_pkg::CMD_IDLE;
    logic o_host_ack, o_host_err, o_cpu_reset, o_ctl_busy, o_ctl_ack, o_boot_busy;
    logic o_scl_oe, o_sda_oe, ee_oe, ak;
    logic [47:0] o_vendor_product_device_ids, ids;
    logic [7:0] o_config, cfgv, bw_data, img_dat;
    rbl_pkg::rbl_ram_s o_ram;
    wire scl = !o_scl_oe;
    wire sda = !(o_sda_oe || ee_oe);
    int n_errors = 0, checks_done = 0, nbw = 0, k, seed;
    logic [15:0] bw_addr, tbl [8];
    assign i_ram_rdata = o_ram.addr[7:0] ^ 8'h5A;
    always #12.5 i_mclk = ~i_mclk;
    rbl_loader rbl_loader_i (.i_mclk, .i_rst, .i_host_we, .i_host_re, .i_host_addr,
        .i_host_wdata, .o_host_rdata, .o_host_ack, .o_host_err, .i_cpu_hold_req,
        .o_cpu_reset, .i_ctl_wr, .i_ctl_cmd, .i_ctl_nack, .i_dat_wr, .i_dat_wdata,
        .o_dat_rdata, .o_ctl_busy, .o_ctl_ack, .o_boot_busy, .o_vendor_product_device_ids,
        .o_config, .o_ram, .i_ram_rdata, .i_scl(scl), .i_sda(sda), .o_scl_oe, .o_sda_oe);
    rbl_ee_model rbl_ee_model_i (.i_scl(scl), .i_sda(sda), .o_sda_oe(ee_oe));
    // count ram writes made by the boot loader
    always @(posedge i_mclk) if (o_ram.we === 1 && o_boot_busy === 1) begin
        nbw++;
        bw_addr = o_ram.addr;
        bw_data = o_ram.wdata;
    end
    function automatic logic win(logic [15:0] a);
        return a <= 16'h3FFF || (a >= 16'hE000 && a <= 16'hE1FF);
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // one host request, entered just after an edge
    task automatic host(input logic we, input logic [15:0] a, input logic ok);
        logic [7:0] d;
        d = 8'($urandom);
        i_host_we = we;
        i_host_re = !we;
        i_host_addr = a;
        i_host_wdata = d;
        @(posedge i_mclk);
        #1;
        i_host_we = 0;
        i_host_re = 0;
        chk("host_ack", 48'(o_host_ack), 48'(ok));
        chk("host_err", 48'(o_host_err), 48'(!ok));
        if (ok && we) chk("ram_wr", 48'({o_ram.we, o_ram.addr, o_ram.wdata}), 48'({1'b1, a, d}));
        if (ok && !we) begin
            chk("ram_rd", 48'({o_ram.re, o_ram.addr}), 48'({1'b1, a}));
            repeat (2) @(posedge i_mclk);
            #1;
            chk("host_rdata", 48'(o_host_rdata), 48'(a[7:0] ^ 8'h5A));
        end
        // let an edge pass so the next request never re-raises in this step
        @(posedge i_mclk);
        #1;
    endtask
    // one runtime command; ack reports a slave ack
    task automatic ctl(input rbl_pkg::rbl_cmd_e c, input logic [7:0] d, output logic ack);
        int w;
        ack = 0;
        i_dat_wr = 1;
        i_dat_wdata = d;
        @(posedge i_mclk);
        #1;
        i_dat_wr = 0;
        i_ctl_wr = 1;
        i_ctl_cmd = c;
        i_ctl_nack = 1;
        @(posedge i_mclk);
        #1;
        i_ctl_wr = 0;
        for (w = 0; w < 9000 && o_ctl_busy !== 0; w++) begin
            ack = ack | (o_ctl_ack === 1);
            @(posedge i_mclk);
            #1;
        end
        ack = ack | (o_ctl_ack === 1);
        @(posedge i_mclk);
        #1;
        ack = ack | (o_ctl_ack === 1);
        if (w == 9000) begin
            n_errors++;
            give_verdict();
        end
    endtask
    // hang guard
    initial begin
        #2400000;
        n_errors++;
        give_verdict();
    end
    initial begin
        seed = $urandom(32'h0000_e946);
        ids = 48'({$urandom, $urandom});
        cfgv = 8'($urandom);
        img_dat = 8'($urandom);
        tbl = '{16'h0000, 16'h3FFF, 16'hE000, 16'hE1FF, 16'h4000, 16'hDFFF, 16'hE200, 16'hFFFF};
        #1;
        foreach (rbl_ee_model_i.mem[j]) rbl_ee_model_i.mem[j] = 8'h00;
        rbl_ee_model_i.mem[0] = IMG_MARK;
        for (k = 0; k < 6; k++) rbl_ee_model_i.mem[k + 1] = ids[47 - 8 * k -: 8];
        rbl_ee_model_i.mem[7] = cfgv;
        rbl_ee_model_i.mem[9] = 8'h01;
        rbl_ee_model_i.mem[10] = 8'hE0;
        rbl_ee_model_i.mem[11] = img_dat;
        repeat (3) @(posedge i_mclk);
        #1;
        i_rst = 0;
        chk("cpu_rst_boot", 48'(o_cpu_reset), 48'h1);
        host(1, 16'h0010, 0);
        for (k = 0; k < 70000 && o_boot_busy !== 0; k++) begin
            @(posedge i_mclk);
            #1;
        end
        if (k == 70000) begin
            n_errors++;
            give_verdict();
        end
        chk("ids", ids, o_vendor_product_device_ids);
        chk("config", 48'(cfgv), 48'(o_config));
        chk("boot_wr", 48'({nbw[7:0], bw_addr, bw_data}),
            48'({8'h01, 16'hE000, img_dat}));
        repeat (2) @(posedge i_mclk);
        #1;
        chk("cpu_free", 48'(o_cpu_reset), 48'h0);
        $display("test boot done");
        host(1, 16'h0000, 0);
        i_cpu_hold_req = 1;
        repeat (2) @(posedge i_mclk);
        #1;
        for (k = 0; k < 16; k++) host(k[0], tbl[k[3:1]], k < 8);
        for (k = 0; k < 24; k++) begin
            bw_addr = 16'($urandom);
            host(k[0], bw_addr, win(bw_addr));
        end
        $display("test host done");
        i_cpu_hold_req = 0;
        ctl(rbl_pkg::CMD_START, 8'h00, ak);
        ctl(rbl_pkg::CMD_WRITE, 8'hA2, ak);
        chk("dev_ack", 48'(ak), 48'h1);
        ctl(rbl_pkg::CMD_WRITE, 8'h00, ak);
        ctl(rbl_pkg::CMD_WRITE, 8'h03, ak);
        ctl(rbl_pkg::CMD_STOP, 8'h00, ak);
        ctl(rbl_pkg::CMD_START, 8'h00, ak);
        ctl(rbl_pkg::CMD_WRITE, 8'hA3, ak);
        ctl(rbl_pkg::CMD_READ, 8'h00, ak);
        chk("rt_read", 48'(ids[31:24]), 48'(o_dat_rdata));
        ctl(rbl_pkg::CMD_STOP, 8'h00, ak);
        ctl(rbl_pkg::CMD_START, 8'h00, ak);
        ctl(rbl_pkg::CMD_WRITE, 8'h40, ak);
        chk("absent_ack", 48'(ak), 48'h0);
        ctl(rbl_pkg::CMD_STOP, 8'h00, ak);
        $display("test runtime done");
        give_verdict();
    end
endmodule
